// file: inc/bpa_defines.vh
`ifndef BPA_DEFINES_VH
`define BPA_DEFINES_VH
// Register byte offsets on APB
`define BPA_OFS_BREV   8'h00
`define BPA_OFS_TPAGE  8'h04
`define BPA_OFS_WPAGE  8'h08
`define BPA_OFS_MODE   8'h0C
`define BPA_OFS_CORE   8'h10
`define BPA_OFS_AGUST  8'h14
`define BPA_OFS_PRGST  8'h18
`define BPA_OFS_RDST   8'h1C
// Field positions
`define BPA_BREV_EN    15
`define BPA_BREV_PIV   14:0
`define BPA_MOD_XEN    15
`define BPA_MOD_XSEL   3:0
`define BPA_MOD_RSEL   11:8
`define BPA_CORE_WEN   2
`define BPA_PAGE_CFG   7
`define BPA_EA_HI      15
// Reset values
`define BPA_RST_BREV   16'h0000
`define BPA_RST_PAGE   8'h00
`define BPA_RST_MOD    16'h0F0F
`define BPA_RST_CORE   16'h0000
// Pointer select that disables a mode
`define BPA_SEL_NONE   4'hF
// Indirect addressing modes
`define BPA_AM_PLAIN   3'h0
`define BPA_AM_POSTINC 3'h1
`define BPA_AM_PREINC  3'h2
`define BPA_AM_POSTDEC 3'h3
`define BPA_AM_PREDEC  3'h4
`define BPA_AM_OFFSET  3'h5
// Program space access kinds
`define BPA_PK_TRL     3'h0
`define BPA_PK_TRH     3'h1
`define BPA_PK_TWL     3'h2
`define BPA_PK_TWH     3'h3
`define BPA_PK_DRD     3'h4
// Program counter step per program word
`define BPA_PC_STEP    24'h000002
`endif

// file: rtl/bpa_agu.v
// How it works
// - Bit reversal needs pointer select not 15, enable set, pre/post increment.
// - Pivot is 15 bits scaled to bytes; accesses are words; LSb forced zero.
// - Only word writes with pre/post increment get reversed addresses.
// - When reversing, pivot is added and the mode offset is ignored.
// - Reversal overrides X write modulo; X read modulo keeps working.
// - Successive addresses follow the mirrored bit order of the index.
// - Table access address is table page above the 16-bit address.
// - Table page bit 7 selects user or configuration memory.
// - Data read with address bit 15 set maps window page and 15 bits.
// - Remapped address bit 15 comes from window page bit 0.
// - Remapping happens only while the window enable bit is set.
// - Remapping is read only and returns the low program word.
// - Program counter steps by two per program word.
// - Low table read in word mode returns program bits 15 to 0.
// - Low table read in byte mode picks a low-word byte by byte select.
// - High table read in word mode returns upper byte, phantom byte zero.
// - High table read in byte mode returns upper byte or zero.
// - Only high table ops reach the upper program byte.
`timescale 1ns/1ns
`include "bpa_defines.vh"
module bpa_agu (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        agu_valid,
  input  wire        agu_write,
  input  wire        agu_word,
  input  wire [2:0]  agu_mode,
  input  wire [3:0]  agu_wreg,
  input  wire [15:0] agu_ptr,
  input  wire [15:0] agu_offset,
  output reg         agu_done,
  output reg  [15:0] agu_ea,
  output reg  [15:0] agu_ptr_next,
  output reg         agu_ptr_wb,
  output reg         agu_bitrev,
  output reg         agu_wmod_en,
  output reg         agu_rmod_en,
  input  wire        prg_valid,
  input  wire [2:0]  prg_kind,
  input  wire        prg_byte,
  input  wire [15:0] prg_ea,
  input  wire [15:0] prg_wdata,
  output reg         prg_bypass,
  output reg         prg_rvalid,
  output reg  [15:0] prg_rdata,
  output reg         mem_req,
  output reg         mem_we,
  output reg  [23:0] mem_addr,
  output reg         mem_cfg,
  output reg  [23:0] mem_wdata,
  output reg  [2:0]  mem_wmask,
  input  wire        mem_rvalid,
  input  wire [23:0] mem_rdata,
  input  wire        pc_advance,
  output reg  [23:0] pc
);

  reg  [15:0] bit_reverse_control;
  reg  [7:0]  table_page;
  reg  [7:0]  program_window_page;
  reg  [15:0] addressing_mode_control;
  reg  [15:0] core_control;
  reg  [15:0] rd_last;
  reg         pend_busy;
  reg  [2:0]  pend_kind;
  reg         pend_byte;
  reg         pend_bs;
  reg  [31:0] next_prdata;
  reg         next_err;
  reg  [15:0] next_ea;
  reg  [15:0] next_ptr;
  reg         next_wb;
  reg  [15:0] next_rdata;
  reg  [23:0] next_wdata;
  reg  [2:0]  next_wmask;
  wire        apb_setup;
  wire        apb_done;
  wire        wr_ok;
  wire        br_sel_ok;
  wire        br_mode_ok;
  wire        br_active;
  wire        xmod_on;
  wire [15:0] pivot;
  wire [15:0] ptr_even;
  wire [15:0] ptr_r;
  wire [15:0] piv_r;
  wire [15:0] sum_r;
  wire [15:0] br_sum;
  wire [15:0] inc_sum;
  wire [15:0] dec_sum;
  wire        is_table;
  wire        is_remap;
  wire        is_read;
  wire [23:0] pc_sum;

  assign apb_setup = psel & ~penable;
  assign apb_done  = psel & penable & pready;
  assign wr_ok     = apb_done & pwrite & ~pslverr;

  // Registered answer in setup gives a fixed one-cycle access phase
  always @* begin
    next_prdata = 32'h00000000;
    next_err    = 1'b0;
    if (paddr == `BPA_OFS_BREV) begin
      next_prdata = {16'h0000, bit_reverse_control};
    end else if (paddr == `BPA_OFS_TPAGE) begin
      next_prdata = {24'h000000, table_page};
    end else if (paddr == `BPA_OFS_WPAGE) begin
      next_prdata = {24'h000000, program_window_page};
    end else if (paddr == `BPA_OFS_MODE) begin
      next_prdata = {16'h0000, addressing_mode_control};
    end else if (paddr == `BPA_OFS_CORE) begin
      next_prdata = {16'h0000, core_control};
    end else if (paddr == `BPA_OFS_AGUST) begin
      next_prdata = {agu_ptr_next, agu_ea};
      next_err    = pwrite;
    end else if (paddr == `BPA_OFS_PRGST) begin
      next_prdata = {8'h00, mem_addr};
      next_err    = pwrite;
    end else if (paddr == `BPA_OFS_RDST) begin
      next_prdata = {16'h0000, rd_last};
      next_err    = pwrite;
    end else begin
      next_err    = 1'b1; // Unmapped offset
    end
  end

  // APB handshake; pready drops right after each completed access
  always @(posedge mclk) begin
    if (!rst_n) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata  <= pwrite ? 32'h00000000 : next_prdata;
      pready  <= 1'b1;
      pslverr <= next_err;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Control registers; a write lands at the completing edge, so the next
  // access request already sees it
  always @(posedge mclk) begin
    if (!rst_n) begin
      bit_reverse_control     <= `BPA_RST_BREV;
      table_page              <= `BPA_RST_PAGE;
      program_window_page     <= `BPA_RST_PAGE;
      addressing_mode_control <= `BPA_RST_MOD;
      core_control            <= `BPA_RST_CORE;
    end else if (wr_ok) begin
      if (paddr == `BPA_OFS_BREV) begin
        bit_reverse_control <= pwdata[15:0];
      end else if (paddr == `BPA_OFS_TPAGE) begin
        table_page <= pwdata[7:0];
      end else if (paddr == `BPA_OFS_WPAGE) begin
        program_window_page <= pwdata[7:0];
      end else if (paddr == `BPA_OFS_MODE) begin
        addressing_mode_control <= pwdata[15:0];
      end else if (paddr == `BPA_OFS_CORE) begin
        core_control <= pwdata[15:0];
      end
    end
  end

  // Enable terms; the stack pointer select of 15 can never reverse
  assign br_sel_ok  = addressing_mode_control[`BPA_MOD_RSEL] != `BPA_SEL_NONE;
  assign br_mode_ok = (agu_mode == `BPA_AM_PREINC) | (agu_mode == `BPA_AM_POSTINC);
  assign br_active  = br_sel_ok & bit_reverse_control[`BPA_BREV_EN] & br_mode_ok
                    & (agu_wreg == addressing_mode_control[`BPA_MOD_RSEL])
                    & agu_write & agu_word;
  assign xmod_on    = addressing_mode_control[`BPA_MOD_XEN]
                    & (addressing_mode_control[`BPA_MOD_XSEL] != `BPA_SEL_NONE)
                    & (agu_wreg == addressing_mode_control[`BPA_MOD_XSEL]);

  // Pivot scaled to bytes; word-only accesses keep the LSb clear
  assign pivot    = {bit_reverse_control[`BPA_BREV_PIV], 1'b0};
  assign ptr_even = {agu_ptr[15:1], 1'b0};

  // Mirror both operands so an ordinary adder carries downward
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_mirror
      assign ptr_r[i]  = ptr_even[15-i];
      assign piv_r[i]  = pivot[15-i];
      assign br_sum[i] = sum_r[15-i];
    end
  endgenerate

  assign sum_r   = ptr_r + piv_r;
  assign inc_sum = agu_ptr + agu_offset;
  assign dec_sum = agu_ptr - agu_offset;

  // Address and write-back selection; reversal ignores the mode offset
  always @* begin
    next_ea  = agu_ptr;
    next_ptr = agu_ptr;
    next_wb  = 1'b0;
    if (br_active) begin
      next_wb  = 1'b1;
      next_ptr = {br_sum[15:1], 1'b0};
      next_ea  = (agu_mode == `BPA_AM_PREINC) ? {br_sum[15:1], 1'b0} : ptr_even;
    end else begin
      case (agu_mode)
        `BPA_AM_POSTINC: begin
          next_ptr = inc_sum;
          next_wb  = 1'b1;
        end
        `BPA_AM_PREINC: begin
          next_ptr = inc_sum;
          next_ea  = inc_sum;
          next_wb  = 1'b1;
        end
        `BPA_AM_POSTDEC: begin
          next_ptr = dec_sum;
          next_wb  = 1'b1;
        end
        `BPA_AM_PREDEC: begin
          next_ptr = dec_sum;
          next_ea  = dec_sum;
          next_wb  = 1'b1;
        end
        `BPA_AM_OFFSET: begin
          next_ea = inc_sum; // Pointer stays unchanged
        end
        default: begin
          next_ea = agu_ptr;
        end
      endcase
    end
  end

  // One-cycle result for each address request
  always @(posedge mclk) begin
    if (!rst_n) begin
      agu_done     <= 1'b0;
      agu_ea       <= 16'h0000;
      agu_ptr_next <= 16'h0000;
      agu_ptr_wb   <= 1'b0;
      agu_bitrev   <= 1'b0;
      agu_wmod_en  <= 1'b0;
      agu_rmod_en  <= 1'b0;
    end else begin
      agu_done    <= agu_valid;
      agu_ptr_wb  <= agu_valid & next_wb;
      agu_bitrev  <= agu_valid & br_active;
      agu_wmod_en <= agu_valid & agu_write & xmod_on & ~br_active;
      agu_rmod_en <= agu_valid & ~agu_write & xmod_on;
      if (agu_valid) begin
        agu_ea       <= next_ea;
        agu_ptr_next <= next_ptr;
      end
    end
  end

  // Program space decode; window reads need address bit 15 and the window enable bit
  assign is_table = (prg_kind == `BPA_PK_TRL) | (prg_kind == `BPA_PK_TRH)
                  | (prg_kind == `BPA_PK_TWL) | (prg_kind == `BPA_PK_TWH);
  assign is_remap = (prg_kind == `BPA_PK_DRD) & prg_ea[`BPA_EA_HI]
                  & core_control[`BPA_CORE_WEN];
  assign is_read  = (prg_kind == `BPA_PK_TRL) | (prg_kind == `BPA_PK_TRH) | is_remap;

  // Write lanes: low writes touch bytes 0-1, high writes byte 2 only
  always @* begin
    next_wdata = 24'h000000;
    next_wmask = 3'b000;
    if (prg_kind == `BPA_PK_TWL) begin
      if (!prg_byte) begin
        next_wdata = {8'h00, prg_wdata};
        next_wmask = 3'b011;
      end else if (prg_ea[0]) begin
        next_wdata = {8'h00, prg_wdata[7:0], 8'h00};
        next_wmask = 3'b010;
      end else begin
        next_wdata = {16'h0000, prg_wdata[7:0]};
        next_wmask = 3'b001;
      end
    end else if (prg_kind == `BPA_PK_TWH) begin
      next_wdata = {prg_wdata[7:0], 16'h0000};
      next_wmask = (prg_byte & prg_ea[0]) ? 3'b000 : 3'b100;
    end
  end

  // Lane mapping of returned program words
  always @* begin
    next_rdata = mem_rdata[15:0];
    case (pend_kind)
      `BPA_PK_TRL: begin
        if (!pend_byte) begin
          next_rdata = mem_rdata[15:0];
        end else begin
          next_rdata = pend_bs ? {8'h00, mem_rdata[15:8]} : {8'h00, mem_rdata[7:0]};
        end
      end
      `BPA_PK_TRH: begin
        if (!pend_byte) begin
          next_rdata = {8'h00, mem_rdata[23:16]};
        end else begin
          next_rdata = pend_bs ? 16'h0000 : {8'h00, mem_rdata[23:16]};
        end
      end
      default: begin
        next_rdata = mem_rdata[15:0];
      end
    endcase
  end

  // Request issue and read return; one read may be outstanding
  always @(posedge mclk) begin
    if (!rst_n) begin
      mem_req    <= 1'b0;
      mem_we     <= 1'b0;
      mem_addr   <= 24'h000000;
      mem_cfg    <= 1'b0;
      mem_wdata  <= 24'h000000;
      mem_wmask  <= 3'b000;
      prg_bypass <= 1'b0;
      prg_rvalid <= 1'b0;
      prg_rdata  <= 16'h0000;
      rd_last    <= 16'h0000;
      pend_busy  <= 1'b0;
      pend_kind  <= `BPA_PK_TRL;
      pend_byte  <= 1'b0;
      pend_bs    <= 1'b0;
    end else begin
      mem_req    <= 1'b0;
      mem_we     <= 1'b0;
      prg_bypass <= 1'b0;
      prg_rvalid <= 1'b0;
      if (pend_busy & mem_rvalid) begin
        pend_busy  <= 1'b0;
        prg_rvalid <= 1'b1;
        prg_rdata  <= next_rdata;
        rd_last    <= next_rdata;
      end
      if (prg_valid & ~pend_busy) begin
        if (is_table) begin
          mem_req   <= 1'b1;
          mem_we    <= ~is_read;
          mem_addr  <= {table_page, prg_ea};
          mem_cfg   <= table_page[`BPA_PAGE_CFG];
          mem_wdata <= next_wdata;
          mem_wmask <= is_read ? 3'b000 : next_wmask;
        end else if (is_remap) begin
          mem_req   <= 1'b1;
          mem_addr  <= {1'b0, program_window_page, prg_ea[14:0]};
          mem_cfg   <= 1'b0;
          mem_wdata <= 24'h000000;
          mem_wmask <= 3'b000;
        end else begin
          prg_bypass <= 1'b1; // Ordinary data space, no remap
        end
        if (is_read) begin
          pend_busy <= 1'b1;
          pend_kind <= prg_kind;
          pend_byte <= prg_byte & ~is_remap;
          pend_bs   <= prg_ea[0];
        end
      end
    end
  end

  // Full-width sum; the carry into bit 23 is cut so user space is kept
  assign pc_sum = pc + `BPA_PC_STEP;

  // Program counter keeps bit 0 clear and stays in user space
  always @(posedge mclk) begin
    if (!rst_n) begin
      pc <= 24'h000000;
    end else if (pc_advance) begin
      pc <= {1'b0, pc_sum[22:0]};
    end
  end

endmodule

// file: bench/bpa_agu_assertions.sv
`timescale 1ns/1ns
`include "bpa_defines.vh"
module bpa_agu_chk (
  input logic        mclk,
  input logic        rst_n,
  input logic        agu_write,
  input logic        agu_word,
  input logic [2:0]  agu_mode,
  input logic        agu_done,
  input logic [15:0] agu_ea,
  input logic        agu_bitrev,
  input logic        agu_wmod_en,
  input logic [2:0]  prg_kind,
  input logic [15:0] prg_ea,
  input logic        mem_req,
  input logic        mem_we,
  input logic [23:0] mem_addr,
  input logic        mem_cfg,
  input logic [2:0]  mem_wmask,
  input logic        pc_advance,
  input logic [23:0] pc
);
  // All checks share the core clock and its reset
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_brev_gate: assert property (agu_done && agu_bitrev |-> $past(agu_write && agu_word &&
    (agu_mode == `BPA_AM_POSTINC || agu_mode == `BPA_AM_PREINC))) else $error("bad reversal");
  chk_brev_mod: assert property (agu_bitrev |-> !agu_wmod_en)
    else $error("write modulo with reversal");
  chk_brev_lsb: assert property (agu_bitrev |-> !agu_ea[0])
    else $error("reversed address odd");
  chk_tbl_addr: assert property (mem_req && $past(prg_kind) != `BPA_PK_DRD
    |-> mem_addr[15:0] == $past(prg_ea)) else $error("table address low part");
  chk_cfg_bit: assert property (mem_req |-> mem_cfg == mem_addr[23])
    else $error("memory select wrong");
  chk_remap_ro: assert property (mem_req && $past(prg_kind) == `BPA_PK_DRD |-> !mem_we &&
    !mem_addr[23] && mem_addr[14:0] == $past(prg_ea[14:0])) else $error("remap wrong");
  chk_low_mask: assert property (mem_req && $past(prg_kind) == `BPA_PK_TWL
    |-> !mem_wmask[2]) else $error("low write hit upper byte");
  chk_pc_step: assert property (rst_n && pc_advance |=>
    pc[22:0] == $past(pc[22:0]) + 23'h2 && !pc[23]) else $error("pc step wrong");
endmodule
bind bpa_agu bpa_agu_chk u_chk (.mclk, .rst_n, .agu_write, .agu_word, .agu_mode,
  .agu_done, .agu_ea, .agu_bitrev, .agu_wmod_en, .prg_kind, .prg_ea, .mem_req,
  .mem_we, .mem_addr, .mem_cfg, .mem_wmask, .pc_advance, .pc);

// file: bench/tb_top.sv
`timescale 1ns/1ns
`include "bpa_defines.vh"
module tb_top;
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        agu_valid, agu_write, agu_word, agu_done, agu_ptr_wb, agu_bitrev;
  logic        agu_wmod_en, agu_rmod_en, prg_valid, prg_byte, prg_bypass, prg_rvalid;
  logic        mem_req, mem_we, mem_cfg, mem_rvalid, pc_advance;
  logic [2:0]  agu_mode, prg_kind, mem_wmask;
  logic [3:0]  agu_wreg;
  logic [15:0] agu_ptr, agu_offset, agu_ea, agu_ptr_next, prg_ea, prg_wdata, prg_rdata;
  logic [23:0] mem_addr, mem_wdata, mem_rdata, pc;
  integer      bad_count, check_count, i;
  bpa_agu u_dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .agu_valid, .agu_write, .agu_word, .agu_mode, .agu_wreg,
    .agu_ptr, .agu_offset, .agu_done, .agu_ea, .agu_ptr_next, .agu_ptr_wb,
    .agu_bitrev, .agu_wmod_en, .agu_rmod_en, .prg_valid, .prg_kind, .prg_byte,
    .prg_ea, .prg_wdata, .prg_bypass, .prg_rvalid, .prg_rdata, .mem_req, .mem_we,
    .mem_addr, .mem_cfg, .mem_wdata, .mem_wmask, .mem_rvalid, .mem_rdata,
    .pc_advance, .pc);
  // Free running core clock
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  function [3:0] rev4(input [3:0] v);
    rev4 = {v[0], v[1], v[2], v[3]};
  endfunction
  task cmp(input [31:0] g, input [31:0] x, input string m);
    check_count++;
    if (g !== x) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, x);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One APB transfer; waits for pready but gives up after a bounded count
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    @(posedge mclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    if (n == 20) begin
      cmp(0, 1, "apb timeout");
      finish_test;
    end
  endtask
  task rd(input [7:0] a, input [31:0] x);
    apb(0, a, 0);
    cmp(q, x, "register read");
    cmp(e, 0, "read error");
  endtask
  // Address request; outputs land one cycle after the request edge
  task agu(input w, input wd, input [2:0] md, input [3:0] r, input [15:0] p);
    @(posedge mclk);
    agu_valid <= 1; agu_write <= w; agu_word <= wd; agu_mode <= md; agu_wreg <= r;
    agu_ptr <= p;
    @(posedge mclk);
    agu_valid <= 0;
    #1;
  endtask
  task neg(input w, input wd, input [2:0] md, input [3:0] r);
    agu(w, wd, md, r, 16'h1004);
    cmp(agu_bitrev, 0, "no reversal");
  endtask
  // Program space access; reads are answered by the memory one cycle later
  task prg(input [2:0] k, input b, input [15:0] a, input [23:0] xa, input [15:0] x);
    @(posedge mclk);
    prg_valid <= 1; prg_kind <= k; prg_byte <= b; prg_ea <= a;
    @(posedge mclk);
    prg_valid <= 0;
    #1;
    cmp(mem_req, 1, "mem request");
    cmp(mem_addr, xa, "program address");
    cmp(mem_cfg, xa[23], "memory select");
    if (k == `BPA_PK_TWL || k == `BPA_PK_TWH) begin
      cmp(mem_we, 1, "write strobe");
      cmp(mem_wmask, x, "lane mask");
    end else begin
      cmp(mem_we, 0, "read strobe");
      @(posedge mclk);
      mem_rvalid <= 1;
      @(posedge mclk);
      mem_rvalid <= 0;
      #1;
      cmp(prg_rvalid, 1, "read valid");
      cmp(prg_rdata, x, "read data");
    end
  endtask
  task byp(input [15:0] a);
    @(posedge mclk);
    prg_valid <= 1; prg_kind <= `BPA_PK_DRD; prg_ea <= a;
    @(posedge mclk);
    prg_valid <= 0;
    #1;
    cmp({prg_bypass, mem_req}, 2'b10, "bypass");
  endtask
  // Hang guard
  initial begin
    #200000;
    cmp(0, 1, "run timeout");
    finish_test;
  end
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, agu_valid, agu_write, agu_word} = 0;
    {agu_mode, agu_wreg, agu_ptr, prg_valid, prg_kind, prg_byte, prg_ea} = 0;
    {mem_rvalid, pc_advance, bad_count, check_count} = 0;
    agu_offset = 16'h0040; // Nonzero so an ignored offset shows
    prg_wdata = 16'h5AA5;
    mem_rdata = 24'hA1B2C3;
    repeat (6) @(posedge mclk);
    rst_n <= 1;
    rd(`BPA_OFS_BREV, 0);
    rd(`BPA_OFS_TPAGE, 0);
    rd(`BPA_OFS_WPAGE, 0);
    rd(`BPA_OFS_MODE, 32'h0F0F);
    rd(`BPA_OFS_CORE, 0);
    apb(1, 8'h20, 0);
    cmp(e, 1, "unmapped");
    apb(1, `BPA_OFS_AGUST, 32'h1234);
    cmp(e, 1, "read only");
    $display("test registers done");
    apb(1, `BPA_OFS_MODE, 32'h8303);
    apb(1, `BPA_OFS_BREV, 32'h8008);
    for (i = 0; i < 15; i++) begin
      agu(1, 1, `BPA_AM_POSTINC, 3, 16'h1000 | {rev4(i), 1'b0});
      cmp(agu_ea, 16'h1000 | {rev4(i), 1'b0}, "reversed ea");
      cmp(agu_ptr_next, 16'h1000 | {rev4(i + 1), 1'b0}, "next ptr");
      cmp({agu_done, agu_bitrev, agu_ptr_wb, agu_wmod_en}, 4'b1110, "flags");
    end
    agu(1, 1, `BPA_AM_PREINC, 3, 16'h1001);
    cmp(agu_ea, 16'h1010, "pre inc ea");
    neg(1, 0, `BPA_AM_POSTINC, 3);
    neg(1, 1, `BPA_AM_POSTDEC, 3);
    neg(1, 1, `BPA_AM_PLAIN, 3);
    neg(1, 1, `BPA_AM_POSTINC, 4);
    neg(0, 1, `BPA_AM_POSTINC, 3);
    cmp(agu_rmod_en, 1, "read modulo");
    apb(1, `BPA_OFS_BREV, 32'h0008);
    neg(1, 1, `BPA_AM_POSTINC, 3);
    cmp(agu_wmod_en, 1, "write modulo");
    apb(1, `BPA_OFS_BREV, 32'h8008);
    apb(1, `BPA_OFS_MODE, 32'h0F03);
    neg(1, 1, `BPA_AM_PREINC, 4'hF);
    rd(`BPA_OFS_AGUST, 32'h10441044);
    $display("test reversal done");
    apb(1, `BPA_OFS_TPAGE, 32'h85);
    rd(`BPA_OFS_TPAGE, 32'h85);
    prg(`BPA_PK_TRL, 0, 16'h4446, 24'h854446, 16'hB2C3);
    prg(`BPA_PK_TRL, 1, 16'h4447, 24'h854447, 16'h00B2);
    prg(`BPA_PK_TRL, 1, 16'h4446, 24'h854446, 16'h00C3);
    prg(`BPA_PK_TRH, 0, 16'h4446, 24'h854446, 16'h00A1);
    prg(`BPA_PK_TRH, 1, 16'h4446, 24'h854446, 16'h00A1);
    prg(`BPA_PK_TRH, 1, 16'h4447, 24'h854447, 16'h0000);
    apb(1, `BPA_OFS_TPAGE, 32'h12);
    prg(`BPA_PK_TWL, 0, 16'h0200, 24'h120200, 16'h0003);
    cmp(mem_wdata[15:0], 16'h5AA5, "low word data");
    prg(`BPA_PK_TWL, 1, 16'h0201, 24'h120201, 16'h0002);
    cmp(mem_wdata[15:8], 8'hA5, "low upper byte data");
    prg(`BPA_PK_TWL, 1, 16'h0200, 24'h120200, 16'h0001);
    prg(`BPA_PK_TWH, 0, 16'h0200, 24'h120200, 16'h0004);
    cmp(mem_wdata[23:16], 8'hA5, "high byte data");
    prg(`BPA_PK_TWH, 1, 16'h0201, 24'h120201, 16'h0000);
    $display("test table done");
    apb(1, `BPA_OFS_WPAGE, 32'h35);
    byp(16'h8123);
    apb(1, `BPA_OFS_CORE, 32'h4);
    prg(`BPA_PK_DRD, 0, 16'h8123, 24'h1A8123, 16'hB2C3);
    apb(1, `BPA_OFS_WPAGE, 32'h34);
    prg(`BPA_PK_DRD, 0, 16'h8123, 24'h1A0123, 16'hB2C3);
    byp(16'h0123);
    rd(`BPA_OFS_PRGST, 32'h001A0123);
    rd(`BPA_OFS_RDST, 32'h0000B2C3);
    $display("test remap done");
    @(posedge mclk);
    pc_advance <= 1;
    repeat (3) @(posedge mclk);
    pc_advance <= 0;
    #1;
    cmp(pc, 24'h000006, "pc");
    $display("test pc done");
    // Mid-run reset must bring state and registers back to their reset values
    @(posedge mclk);
    rst_n <= 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1;
    #1;
    cmp(pc, 0, "pc after reset");
    rd(`BPA_OFS_BREV, 0);
    rd(`BPA_OFS_MODE, 32'h0F0F);
    rd(`BPA_OFS_TPAGE, 0);
    $display("test reset done");
    finish_test;
  end
endmodule
